// File: readout_cfg_pkg.sv
// Package with register map, field layout and reset values of readout config
package readout_cfg_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFF_INTEG_CFG = 8'h15;
   localparam logic [7:0] OFF_ROW_FIRST = 8'h19;
   localparam logic [7:0] OFF_ROW_LAST = 8'h1a;
   localparam logic [7:0] OFF_ROW_LOW = 8'h1b;
   localparam logic [7:0] OFF_COL_FIRST = 8'h1c;
   localparam logic [7:0] OFF_COL_LAST = 8'h1d;
   localparam logic [7:0] OFF_COL_LOW = 8'h1e;
   localparam logic [7:0] OFF_FGAP_UP = 8'h20;
   localparam logic [7:0] OFF_FGAP_LO = 8'h21;
   localparam logic [7:0] OFF_RGAP_UP = 8'h22;
   localparam logic [7:0] OFF_RGAP_LO = 8'h23;
   localparam logic [7:0] OFF_EXP_UP = 8'h24;
   localparam logic [7:0] OFF_EXP_LO = 8'h25;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_INTEG_CFG = 8'h08;
   localparam logic [7:0] RST_ROW_FIRST = 8'h00;
   localparam logic [7:0] RST_ROW_LAST = 8'h1b;
   localparam logic [7:0] RST_ROW_LOW = 8'h23;
   localparam logic [7:0] RST_COL_FIRST = 8'h00;
   localparam logic [7:0] RST_COL_LAST = 8'h28;
   localparam logic [7:0] RST_COL_LOW = 8'h23;
   localparam logic [7:0] RST_FGAP_UP = 8'h00;
   localparam logic [7:0] RST_FGAP_LO = 8'h08;
   localparam logic [7:0] RST_RGAP_UP = 8'h00;
   localparam logic [7:0] RST_RGAP_LO = 8'h08;
   localparam logic [7:0] RST_EXP_UP = 8'h00;
   localparam logic [7:0] RST_EXP_LO = 8'h00;
   // ==========================================================
   // Implemented-bit masks; reserved bits read zero
   localparam logic [7:0] MASK_INTEG_CFG = 8'h0f;
   localparam logic [7:0] MASK_LOW_BITS = 8'h3f;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_FGAP_LO = 8'h7f;
   localparam logic [7:0] MASK_RGAP_LO = 8'h1f;
   localparam logic [7:0] MASK_EXP_UP = 8'h0f;
   localparam logic [7:0] MASK_EXP_LO = 8'h7f;
   // ==========================================================
   // Field positions
   localparam int PARTIAL_EN_BIT = 3;
   localparam int FIRST_B2_BIT = 5;
   localparam int LAST_B2_BIT = 2;
   localparam logic [1:0] FIRST_LOW_FIXED = 2'h0;
   localparam logic [1:0] LAST_LOW_FIXED = 2'h3;
   // Top bit of the field each lower gap and exposure byte contributes
   localparam int FGAP_LO_MSB = 6;
   localparam int RGAP_LO_MSB = 4;
   localparam int EXP_UP_MSB = 3;
   localparam int EXP_LO_MSB = 6;
   localparam int NUM_REGS = 13;
   // ==========================================================
   // Register index used by the shadow store
   typedef enum logic [3:0] {
      IDX_INTEG_CFG = 4'h0, IDX_ROW_FIRST = 4'h1, IDX_ROW_LAST = 4'h2,
      IDX_ROW_LOW = 4'h3, IDX_COL_FIRST = 4'h4, IDX_COL_LAST = 4'h5,
      IDX_COL_LOW = 4'h6, IDX_FGAP_UP = 4'h7, IDX_FGAP_LO = 4'h8,
      IDX_RGAP_UP = 4'h9, IDX_RGAP_LO = 4'ha, IDX_EXP_UP = 4'hb,
      IDX_EXP_LO = 4'hc, IDX_NONE = 4'hf
   } reg_idx_t;
   // Commit sequencer states, Gray coded except LOAD back to IDLE, which flips both bits
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_LOAD = 2'b11
   } commit_state_t;
endpackage

// File: cfg_bank_if.sv
// Interface carrying the shadow image between register file and commit stage
`timescale 1ns/10ps
interface cfg_bank_if;
   import readout_cfg_pkg::*;
   logic [7:0] shadow [NUM_REGS];
   logic load;
   modport producer (output shadow, input load);
   modport consumer (input shadow, output load);
endinterface

// File: cfg_commit.sv
// Frame-boundary commit of the shadow image into the active set
`timescale 1ns/10ps
module cfg_commit
   import readout_cfg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic frame_start_i,
   input wire logic pending_i,
   cfg_bank_if.consumer bank,
   output logic [7:0] active_o [NUM_REGS]
);
   commit_state_t state_reg;
   commit_state_t state_next;

   // ===========================================================
   // Sequencer: arm on pending write, load at frame boundary
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (pending_i) begin
               state_next = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (frame_start_i) begin
               state_next = ST_LOAD;
            end
         end
         ST_LOAD: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bank.load = (state_reg == ST_LOAD);

   // Active copy only moves in the load cycle, never mid frame
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         active_o[IDX_INTEG_CFG] <= RST_INTEG_CFG;
         active_o[IDX_ROW_FIRST] <= RST_ROW_FIRST;
         active_o[IDX_ROW_LAST] <= RST_ROW_LAST;
         active_o[IDX_ROW_LOW] <= RST_ROW_LOW;
         active_o[IDX_COL_FIRST] <= RST_COL_FIRST;
         active_o[IDX_COL_LAST] <= RST_COL_LAST;
         active_o[IDX_COL_LOW] <= RST_COL_LOW;
         active_o[IDX_FGAP_UP] <= RST_FGAP_UP;
         active_o[IDX_FGAP_LO] <= RST_FGAP_LO;
         active_o[IDX_RGAP_UP] <= RST_RGAP_UP;
         active_o[IDX_RGAP_LO] <= RST_RGAP_LO;
         active_o[IDX_EXP_UP] <= RST_EXP_UP;
         active_o[IDX_EXP_LO] <= RST_EXP_LO;
      end else if (state_reg == ST_LOAD) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            active_o[i] <= bank.shadow[i]; // R19
         end
      end
   end
endmodule

// File: readout_window_timing_config.sv
// Top of the double-buffered readout window and timing configuration set
// Function
// R1: config bit 3 enables partial frame integration; resets to 0x08.
// R2: host writes zeros to integration config bits 2:0; bits 7:4 reserved.
// R3: first row address bits 10:3 from upper, bit 2 from low bit 5.
// R4: first row address low two bits forced zero; bits 4:3 kept, unused.
// R5: last row address bits 10:3 from upper, bit 2 from low bit 2.
// R6: last row address low two bits forced to 11; bits 1:0 unused.
// R7: first column address bits 10:3 from upper, bit 2 from low bit 5.
// R8: first column address low two bits forced zero; bits 4:3 unused.
// R9: last column address bits 10:3 from upper, bit 2 from low bit 2.
// R10: last column address low two bits forced to 11; bits 1:0 unused.
// R11: host should write all window registers after power-up.
// R12: 15-bit frame gap from upper bits 14:7 and lower bits 6:0.
// R13: host must not program a frame gap above 32767.
// R14: 13-bit row gap from upper bits 12:5 and lower bits 4:0.
// R15: 11-bit integration time counts rows ahead; bits 10:7 in upper.
// R16: host keeps integration time within the active window rows.
// R17: all registers read/write and shadowed before timing logic uses them.
// R18: integration time bits 6:0 in lower register at 0x25, bit 7 reserved.
// R19: shadow values move to the active set at the next frame boundary.
// R20: reads return last written implemented bits; reserved bits read zero.
`timescale 1ns/10ps
module readout_window_timing_config
   import readout_cfg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic soft_rst_i,
   input wire logic wr_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   output logic hit_o,
   input wire logic frame_start_i,
   output logic update_pending_o,
   output logic partial_frame_integration_enable_o,
   output logic [10:0] first_row_address_o,
   output logic [10:0] last_row_address_o,
   output logic [10:0] first_column_address_o,
   output logic [10:0] last_column_address_o,
   output logic [14:0] frame_gap_o,
   output logic [12:0] row_gap_o,
   output logic [10:0] exposure_rows_o
);
   cfg_bank_if bank ();
   logic [7:0] shadow_reg [NUM_REGS];
   logic [7:0] active [NUM_REGS];
   logic pending_reg;
   logic rst_any;
   reg_idx_t wr_idx;

   // ===========================================================
   // Address decode shared by read and write paths
   function automatic reg_idx_t decode(input logic [7:0] a);
      case (a)
         OFF_INTEG_CFG: decode = IDX_INTEG_CFG;
         OFF_ROW_FIRST: decode = IDX_ROW_FIRST;
         OFF_ROW_LAST: decode = IDX_ROW_LAST;
         OFF_ROW_LOW: decode = IDX_ROW_LOW;
         OFF_COL_FIRST: decode = IDX_COL_FIRST;
         OFF_COL_LAST: decode = IDX_COL_LAST;
         OFF_COL_LOW: decode = IDX_COL_LOW;
         OFF_FGAP_UP: decode = IDX_FGAP_UP;
         OFF_FGAP_LO: decode = IDX_FGAP_LO;
         OFF_RGAP_UP: decode = IDX_RGAP_UP;
         OFF_RGAP_LO: decode = IDX_RGAP_LO;
         OFF_EXP_UP: decode = IDX_EXP_UP;
         OFF_EXP_LO: decode = IDX_EXP_LO;
         default: decode = IDX_NONE;
      endcase
   endfunction

   // Mask of bits that are stored; the rest are reserved
   function automatic logic [7:0] impl_mask(input reg_idx_t i);
      case (i)
         IDX_INTEG_CFG: impl_mask = MASK_INTEG_CFG;
         IDX_ROW_LOW: impl_mask = MASK_LOW_BITS;
         IDX_COL_LOW: impl_mask = MASK_LOW_BITS;
         IDX_FGAP_LO: impl_mask = MASK_FGAP_LO;
         IDX_RGAP_LO: impl_mask = MASK_RGAP_LO;
         IDX_EXP_UP: impl_mask = MASK_EXP_UP;
         IDX_EXP_LO: impl_mask = MASK_EXP_LO;
         IDX_NONE: impl_mask = 8'h00;
         default: impl_mask = MASK_FULL;
      endcase
   endfunction

   // Window address: upper byte, one programmable bit, two fixed bits
   function automatic logic [10:0] win_addr(input logic [7:0] upper,
                                            input logic b2,
                                            input logic [1:0] fixed);
      win_addr = {upper, b2, fixed};
   endfunction

   assign rst_any = sys_rst_i | soft_rst_i;
   assign wr_idx = decode(addr_i);

   // ===========================================================
   // Shadow stage, written by the host; soft reset restores defaults
   always_ff @(posedge sys_clk_i) begin
      if (rst_any) begin
         shadow_reg[IDX_INTEG_CFG] <= RST_INTEG_CFG; // R1
         shadow_reg[IDX_ROW_FIRST] <= RST_ROW_FIRST;
         shadow_reg[IDX_ROW_LAST] <= RST_ROW_LAST;
         shadow_reg[IDX_ROW_LOW] <= RST_ROW_LOW;
         shadow_reg[IDX_COL_FIRST] <= RST_COL_FIRST;
         shadow_reg[IDX_COL_LAST] <= RST_COL_LAST;
         shadow_reg[IDX_COL_LOW] <= RST_COL_LOW;
         shadow_reg[IDX_FGAP_UP] <= RST_FGAP_UP;
         shadow_reg[IDX_FGAP_LO] <= RST_FGAP_LO;
         shadow_reg[IDX_RGAP_UP] <= RST_RGAP_UP;
         shadow_reg[IDX_RGAP_LO] <= RST_RGAP_LO;
         shadow_reg[IDX_EXP_UP] <= RST_EXP_UP;
         shadow_reg[IDX_EXP_LO] <= RST_EXP_LO;
      end else if (wr_en_i && wr_idx != IDX_NONE) begin
         // Ignored low address bits are still stored for readback
         shadow_reg[wr_idx] <= wdata_i & impl_mask(wr_idx); // R17 R18 R20
      end
   end

   // Share the shadow image with the commit stage
   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         bank.shadow[i] = shadow_reg[i];
      end
   end

   // ===========================================================
   // Pending flag: a write in the load cycle wins over the clear
   always_ff @(posedge sys_clk_i) begin
      if (rst_any) begin
         pending_reg <= 1'b0;
      end else if (wr_en_i && wr_idx != IDX_NONE) begin
         pending_reg <= 1'b1;
      end else if (bank.load) begin
         pending_reg <= 1'b0;
      end
   end
   assign update_pending_o = pending_reg;

   cfg_commit u_commit (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(rst_any),
      .frame_start_i(frame_start_i),
      .pending_i(pending_reg),
      .bank(bank.consumer),
      .active_o(active)
   );

   // ===========================================================
   // Read path returns the shadow value; reserved bits are zero
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rdata_o <= 8'h00;
         hit_o <= 1'b0;
      end else begin
         hit_o <= (decode(addr_i) != IDX_NONE);
         if (decode(addr_i) != IDX_NONE) begin
            rdata_o <= shadow_reg[decode(addr_i)]; // R20
         end else begin
            rdata_o <= 8'h00;
         end
      end
   end

   // ===========================================================
   // Outputs to timing logic, registered from the active set
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         partial_frame_integration_enable_o <= RST_INTEG_CFG[PARTIAL_EN_BIT];
         first_row_address_o <= 11'h000;
         last_row_address_o <= 11'h000;
         first_column_address_o <= 11'h000;
         last_column_address_o <= 11'h000;
         frame_gap_o <= 15'h0000;
         row_gap_o <= 13'h0000;
         exposure_rows_o <= 11'h000;
      end else begin
         partial_frame_integration_enable_o <=
            active[IDX_INTEG_CFG][PARTIAL_EN_BIT]; // R1
         first_row_address_o <= win_addr(active[IDX_ROW_FIRST],
            active[IDX_ROW_LOW][FIRST_B2_BIT], FIRST_LOW_FIXED); // R3 R4
         last_row_address_o <= win_addr(active[IDX_ROW_LAST],
            active[IDX_ROW_LOW][LAST_B2_BIT], LAST_LOW_FIXED); // R5 R6
         first_column_address_o <= win_addr(active[IDX_COL_FIRST],
            active[IDX_COL_LOW][FIRST_B2_BIT], FIRST_LOW_FIXED); // R7 R8
         last_column_address_o <= win_addr(active[IDX_COL_LAST],
            active[IDX_COL_LOW][LAST_B2_BIT], LAST_LOW_FIXED); // R9 R10
         frame_gap_o <= {active[IDX_FGAP_UP],
            active[IDX_FGAP_LO][FGAP_LO_MSB:0]}; // R12
         row_gap_o <= {active[IDX_RGAP_UP],
            active[IDX_RGAP_LO][RGAP_LO_MSB:0]}; // R14
         exposure_rows_o <= {active[IDX_EXP_UP][EXP_UP_MSB:0],
            active[IDX_EXP_LO][EXP_LO_MSB:0]}; // R15 R18
      end
   end
endmodule

// File: readout_window_timing_config_properties.sv
// Port assertions for the readout window and timing configuration set
`timescale 1ns/10ps
module readout_window_timing_config_properties
   import readout_cfg_pkg::*;
(
   input wire logic sys_clk_i, sys_rst_i, soft_rst_i, wr_en_i,
   input wire logic [7:0] addr_i, wdata_i, rdata_o,
   input wire logic hit_o, frame_start_i, update_pending_o,
   input wire logic partial_frame_integration_enable_o,
   input wire logic [10:0] first_row_address_o, last_row_address_o,
   input wire logic [10:0] first_column_address_o, last_column_address_o,
   input wire logic [14:0] frame_gap_o,
   input wire logic [12:0] row_gap_o,
   input wire logic [10:0] exposure_rows_o
);
   // ==========================================================
   // Decode of the register map as seen from the port
   logic mapped;
   assign mapped = addr_i inside {OFF_INTEG_CFG, [OFF_ROW_FIRST:OFF_COL_LOW],
      [OFF_FGAP_UP:OFF_EXP_LO]};
   default clocking dc @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i || soft_rst_i);
   // ==========================================================
   // Commit steps; the quiet bus keeps a late write from re-arming
   sequence s_boundary;
      update_pending_o && $past(update_pending_o) && frame_start_i && !wr_en_i;
   endsequence
   sequence s_quiet;
      (!wr_en_i) [*4];
   endsequence
   sequence s_settled;
      (!update_pending_o) [*3];
   endsequence
   a_write_sets_pending:
      assert property (wr_en_i && mapped |=> update_pending_o)
      else $error("pending flag not raised by a write");
   a_commit_clears_pending:
      assert property (s_boundary ##1 s_quiet |-> !update_pending_o)
      else $error("pending flag left set after a commit");
   a_outputs_hold_idle:
      assert property (s_settled |=> $stable({first_row_address_o,
         last_row_address_o, first_column_address_o, last_column_address_o,
         frame_gap_o, row_gap_o, exposure_rows_o,
         partial_frame_integration_enable_o}))
      else $error("timing outputs moved without a commit");
   a_mapped_hit:
      assert property (mapped |=> hit_o)
      else $error("mapped address gave no hit");
   a_unmapped_reads_zero:
      assert property (!mapped |=> !hit_o && rdata_o == 8'h00)
      else $error("unmapped address answered");
   a_first_row_low:
      assert property (!$past(sys_rst_i) && !$past(soft_rst_i) |->
         first_row_address_o[1:0] == FIRST_LOW_FIXED)
      else $error("first row low bits not zero");
   a_last_row_low:
      assert property (!$past(sys_rst_i) && !$past(soft_rst_i) |->
         last_row_address_o[1:0] == LAST_LOW_FIXED)
      else $error("last row low bits not three");
   a_partial_after_reset:
      assert property ($fell(sys_rst_i) |-> partial_frame_integration_enable_o)
      else $error("partial integration not enabled after reset");
endmodule
bind readout_window_timing_config readout_window_timing_config_properties
   chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
   .soft_rst_i(soft_rst_i), .wr_en_i(wr_en_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
   .frame_start_i(frame_start_i), .update_pending_o(update_pending_o),
   .partial_frame_integration_enable_o(partial_frame_integration_enable_o),
   .first_row_address_o(first_row_address_o),
   .last_row_address_o(last_row_address_o),
   .first_column_address_o(first_column_address_o),
   .last_column_address_o(last_column_address_o),
   .frame_gap_o(frame_gap_o), .row_gap_o(row_gap_o),
   .exposure_rows_o(exposure_rows_o));

// File: readout_host_model.sv
// Host controller model that programs the configuration bytes
`timescale 1ns/10ps
module readout_host_model
   import readout_cfg_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic hit_i,
   output logic wr_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   initial begin
      wr_en_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // ==========================================================
   // One-cycle write; data is scrambled afterwards so stale bytes show
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_en_o <= 1'b1;
      addr_o <= a;
      wdata_o <= (a == OFF_INTEG_CFG) ? {d[7:3], 3'h0} : d;
      @(posedge sys_clk_i);
      wr_en_o <= 1'b0;
      wdata_o <= ~d;
   endtask
   // Read data is registered, so it is taken just after the next edge
   task automatic read(input logic [7:0] a, output logic [7:0] d,
      output logic h);
      @(posedge sys_clk_i);
      addr_o <= a;
      @(posedge sys_clk_i);
      #1;
      d = rdata_i;
      h = hit_i;
   endtask
endmodule

// File: tb_readout_window_timing_config.sv
// Self-checking bench for the readout window and timing configuration set
`timescale 1ns/10ps
module tb_readout_window_timing_config
   import readout_cfg_pkg::*;
;
   // ==========================================================
   // Register tables in the order of the design's shadow index
   localparam logic [7:0] OFFS [NUM_REGS] = '{OFF_INTEG_CFG, OFF_ROW_FIRST,
      OFF_ROW_LAST, OFF_ROW_LOW, OFF_COL_FIRST, OFF_COL_LAST, OFF_COL_LOW,
      OFF_FGAP_UP, OFF_FGAP_LO, OFF_RGAP_UP, OFF_RGAP_LO, OFF_EXP_UP,
      OFF_EXP_LO};
   localparam logic [7:0] RSTS [NUM_REGS] = '{RST_INTEG_CFG, RST_ROW_FIRST,
      RST_ROW_LAST, RST_ROW_LOW, RST_COL_FIRST, RST_COL_LAST, RST_COL_LOW,
      RST_FGAP_UP, RST_FGAP_LO, RST_RGAP_UP, RST_RGAP_LO, RST_EXP_UP,
      RST_EXP_LO};
   localparam logic [7:0] MASKS [NUM_REGS] = '{MASK_INTEG_CFG, MASK_FULL,
      MASK_FULL, MASK_LOW_BITS, MASK_FULL, MASK_FULL, MASK_LOW_BITS,
      MASK_FULL, MASK_FGAP_LO, MASK_FULL, MASK_RGAP_LO, MASK_EXP_UP,
      MASK_EXP_LO};
   localparam logic [7:0] GAPS [3] = '{8'h14, 8'h1f, 8'h26};
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, soft_rst_i = 1'b0;
   logic frame_start_i = 1'b0, h;
   logic wr_en_i, hit_o, update_pending_o, partial_frame_integration_enable_o;
   logic [7:0] addr_i, wdata_i, rdata_o, d;
   logic [10:0] first_row_address_o, last_row_address_o, exposure_rows_o;
   logic [10:0] first_column_address_o, last_column_address_o;
   logic [14:0] frame_gap_o;
   logic [12:0] row_gap_o;
   logic [7:0] shd [NUM_REGS], act [NUM_REGS];
   logic [10:0] lim;
   int bad_count = 0, comparisons = 0, seed = 90, cycles = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   // Hang guard; a full run needs well under a thousand cycles
   always @(posedge sys_clk_i) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         bad_count = bad_count + 1;
         complete_run();
      end
   end
   readout_host_model host (.sys_clk_i(sys_clk_i), .rdata_i(rdata_o),
      .hit_i(hit_o), .wr_en_o(wr_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
   readout_window_timing_config DUT (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i), .wr_en_i(wr_en_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
      .frame_start_i(frame_start_i), .update_pending_o(update_pending_o),
      .partial_frame_integration_enable_o(partial_frame_integration_enable_o),
      .first_row_address_o(first_row_address_o),
      .last_row_address_o(last_row_address_o),
      .first_column_address_o(first_column_address_o),
      .last_column_address_o(last_column_address_o),
      .frame_gap_o(frame_gap_o), .row_gap_o(row_gap_o),
      .exposure_rows_o(exposure_rows_o));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Rows spanned by the shadowed window; 0 when inverted or wrapping
   function automatic logic [10:0] win_rows();
      logic [10:0] top_row, end_row;
      top_row = {shd[1], shd[3][5], 2'h0};
      end_row = {shd[2], shd[3][2], 2'h3};
      win_rows = (end_row >= top_row) ? 11'(end_row - top_row + 11'h001) :
         11'h000;
   endfunction
   // Reads show the last written byte, not the committed one
   task automatic check_reads();
      foreach (OFFS[i]) begin
         host.read(OFFS[i], d, h);
         chk(d, shd[i]);
         chk(h, 1'b1);
      end
   endtask
   task automatic check_outs();
      chk(partial_frame_integration_enable_o, act[0][3]);
      chk(first_row_address_o, {act[1], act[3][5], 2'h0});
      chk(last_row_address_o, {act[2], act[3][2], 2'h3});
      chk(first_column_address_o, {act[4], act[6][5], 2'h0});
      chk(last_column_address_o, {act[5], act[6][2], 2'h3});
      chk(frame_gap_o, {act[7], act[8][6:0]});
      chk(row_gap_o, {act[9], act[10][4:0]});
      chk(exposure_rows_o, {act[11][3:0], act[12][6:0]});
   endtask
   // Boundary pulse only after the pending flag has had time to arm
   task automatic commit();
      repeat (2) @(posedge sys_clk_i);
      frame_start_i <= 1'b1;
      #1;
      chk(update_pending_o, 1'b1);
      @(posedge sys_clk_i);
      frame_start_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      #1;
      chk(update_pending_o, 1'b0);
      act = shd;
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      foreach (shd[i]) shd[i] = RSTS[i] & MASKS[i];
      act = shd;
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      #1;
      check_outs();
      check_reads();
      $display("reset value test done");
      // All ones, all zeros, then random bytes into every register
      for (int k = 0; k < 6; k++) begin
         foreach (OFFS[i]) begin
            d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
            // Host keeps the exposure within the rows of its window
            lim = win_rows();
            if (i == IDX_EXP_UP) d = d & 8'(lim >> 7);
            if (i == IDX_EXP_LO && shd[IDX_EXP_UP][3:0] == lim[10:7])
               d = d & {1'b0, lim[6:0]};
            host.write(OFFS[i], d);
            shd[i] = d & MASKS[i] & ((i == 0) ? 8'hf8 : 8'hff);
         end
         check_reads();
         check_outs();
         commit();
         check_outs();
         $display("random pass %0d done", k);
      end
      foreach (GAPS[j]) begin
         host.write(GAPS[j], 8'hff);
         host.read(GAPS[j], d, h);
         chk({h, d}, 9'h000);
         chk(update_pending_o, 1'b0);
      end
      $display("unmapped test done");
      @(posedge sys_clk_i);
      soft_rst_i <= 1'b1;
      @(posedge sys_clk_i);
      soft_rst_i <= 1'b0;
      foreach (shd[i]) shd[i] = RSTS[i] & MASKS[i];
      act = shd;
      repeat (2) @(posedge sys_clk_i);
      #1;
      check_outs();
      check_reads();
      $display("soft reset test done");
      complete_run();
   end
endmodule
